// File: rtl/ebot_cfg.svh
`ifndef EBOT_CFG_SVH
`define EBOT_CFG_SVH
// Register byte addresses on the Wishbone bus
`define EBOT_ADDR_CTRL       4'h0
`define EBOT_ADDR_COUNT      4'h4
`define EBOT_ADDR_MASK       4'h8
`define EBOT_ADDR_FLAGS      4'hC
`define EBOT_ADDR_SFR        5'h10
// Field positions
`define EBOT_CS_MSB          2
`define EBOT_CS_LSB          0
`define EBOT_OVF_BIT         0
`define EBOT_PSR_BIT         0
// Reset values
`define EBOT_CTRL_RST        8'h00
`define EBOT_COUNT_RST       8'h00
`define EBOT_MASK_RST        8'h00
`define EBOT_FLAGS_RST       8'h00
// Counter limits
`define EBOT_COUNT_MAX       8'hFF
`define EBOT_COUNT_BOTTOM    8'h00
// Prescaler tap masks: tick when the low bits of the counter are all ones
`define EBOT_DIV8_MASK       10'h007
`define EBOT_DIV64_MASK      10'h03F
`define EBOT_DIV256_MASK     10'h0FF
`define EBOT_DIV1024_MASK    10'h3FF
`endif

// File: rtl/ebot_pkg.sv
package ebot_pkg;
	// Clock-select codes of the control register
	typedef enum logic [2:0] {
		EBOT_CS_STOP,
		EBOT_CS_DIV1,
		EBOT_CS_DIV8,
		EBOT_CS_DIV64,
		EBOT_CS_DIV256,
		EBOT_CS_DIV1024,
		EBOT_CS_EXT_FALL,
		EBOT_CS_EXT_RISE
	} ebot_cs_t;

	// Bus slave phase
	typedef enum logic {
		EBOT_BUS_IDLE,
		EBOT_BUS_ACK
	} ebot_bus_t;
endpackage

// File: rtl/ebot_tick_if.sv
`timescale 1ns/1ps
// Prescaler taps and external edge strobes toward the counter
interface ebot_tick_if;
	logic	presc_clear;	// Restart prescaler
	logic	tap_div8;	// One-cycle tap pulses
	logic	tap_div64;
	logic	tap_div256;
	logic	tap_div1024;
	logic	ext_rise;	// One-cycle edge pulses
	logic	ext_fall;

	modport presc (
		input	presc_clear,
		output	tap_div8,
		output	tap_div64,
		output	tap_div256,
		output	tap_div1024
	);
	modport edge_src (
		output	ext_rise,
		output	ext_fall
	);
	modport timer (
		output	presc_clear,
		input	tap_div8,
		input	tap_div64,
		input	tap_div256,
		input	tap_div1024,
		input	ext_rise,
		input	ext_fall
	);
endinterface

// File: rtl/ebot_prescaler.sv
`timescale 1ns/1ps
`include "ebot_cfg.svh"
// Free-running 10-bit prescaler shared with the other timer
module ebot_prescaler
	import ebot_pkg::*;
(
	input	wire logic	i_ref_clk,
	input	wire logic	i_rstn,
	ebot_tick_if.presc	tk
);
	typedef struct packed {
		logic [9:0]	cnt;	// Prescaler count
	} ebot_presc_st_t;

	ebot_presc_st_t	st_r;	// Registered state
	ebot_presc_st_t	st_nxt;	// Next state

	// Pulses when all masked low bits are ones
	function automatic logic tap_hit(input logic [9:0] c,
		input logic [9:0] m);
		tap_hit = ((c & m) == m);
	endfunction

	// Runs whatever the clock select is; clear restarts it
	always_comb begin
		st_nxt = st_r;
		if (tk.presc_clear) begin
			st_nxt.cnt = 10'h000;
		end else begin
			st_nxt.cnt = st_r.cnt + 10'h001;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Tap pulses, suppressed during a clear
	assign tk.tap_div8    = !tk.presc_clear && tap_hit(st_r.cnt,
		`EBOT_DIV8_MASK);
	assign tk.tap_div64   = !tk.presc_clear && tap_hit(st_r.cnt,
		`EBOT_DIV64_MASK);
	assign tk.tap_div256  = !tk.presc_clear && tap_hit(st_r.cnt,
		`EBOT_DIV256_MASK);
	assign tk.tap_div1024 = !tk.presc_clear && tap_hit(st_r.cnt,
		`EBOT_DIV1024_MASK);
endmodule

// File: rtl/ebot_edge_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser and edge detector for the count pin
module ebot_edge_sync
	import ebot_pkg::*;
(
	input	wire logic	i_ref_clk,
	input	wire logic	i_rstn,
	input	wire logic	i_pin,
	ebot_tick_if.edge_src	tk
);
	typedef struct packed {
		logic	meta;	// First stage, read only by sync
		logic	sync;	// Second stage
		logic	last;	// Previous synchronised level
	} ebot_edge_st_t;

	ebot_edge_st_t	st_r;	// Registered state
	ebot_edge_st_t	st_nxt;	// Next state

	// Sample once per clock, then keep history
	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = i_pin;
		st_nxt.sync = st_r.meta;
		st_nxt.last = st_r.sync;
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// One pulse per detected edge
	assign tk.ext_rise = st_r.sync && !st_r.last;
	assign tk.ext_fall = !st_r.sync && st_r.last;
endmodule

// File: rtl/ebot_timer.sv
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "ebot_cfg.svh"
// Functional notes
// - Eight-bit counter reachable as one register.
// - Count up one per active tick.
// - Clock-select zero stops the counter.
// - Counter readable and writable at any time.
// - Software write beats a same-cycle count.
// - Up only, wraps 0xFF to 0x00.
// - Maximum indication while counter is 0xFF.
// - Overflow flag set on wrap, never cleared by counting.
// - Codes 1-5: undivided, /8, /64, /256, /1024.
// - Code 6 falling edges, 7 rising edges.
// - Pin edges count even when driven locally.
// - Interrupt needs enable, global enable, flag.
// - Vector entry clears the overflow flag.
// - Writing one clears flag; zero keeps.
// - Prescaler free-running and shared.
// - Prescaler reset bit self-clears, reads zero.
// - Pin synchronised and edge detected.
module ebot_timer
	import ebot_pkg::*;
(
	input	wire logic		i_ref_clk,
	input	wire logic		i_rstn,
	input	wire logic		i_wb_cyc,
	input	wire logic		i_wb_stb,
	input	wire logic		i_wb_we,
	input	wire logic [4:0]	i_wb_adr,
	input	wire logic [3:0]	i_wb_sel,
	input	wire logic [31:0]	i_wb_dat,
	output	logic [31:0]		o_wb_dat,
	output	logic			o_wb_ack,
	input	wire logic		i_ext_count_pin,
	input	wire logic		i_global_irq_enable,
	input	wire logic		i_ovf_vector_taken,
	output	logic			o_irq,
	output	logic			o_count_max,
	output	logic			o_presc_clear
);
	// Complete state of the timer and its bus slave
	typedef struct packed {
		ebot_bus_t	bus;		// Bus phase
		logic [31:0]	rdata;		// Read data
		logic [2:0]	clk_sel;	// Clock-select field
		logic [7:0]	count;
		logic		ovf_en;		// Overflow irq enable
		logic		ovf_flag;	// Overflow flag
		logic		presc_clr;	// Prescaler reset pulse
		logic		irq;		// Registered irq
	} ebot_st_t;

	ebot_st_t	st_r;		// Registered state
	ebot_st_t	st_nxt;		// Next state
	ebot_cs_t	sel;		// Decoded clock select
	logic		tick;		// Selected timer tick
	logic		wr;		// Write strobe, one per access
	logic		rd;		// Read strobe, one per access
	logic		flag_set;	// Overflow event this cycle
	logic [7:0]	wbyte;		// Low write byte

	ebot_tick_if	tk ();		// Tick sources

	// Shared prescaler
	ebot_prescaler u_presc (
		.i_ref_clk	(i_ref_clk),
		.i_rstn		(i_rstn),
		.tk		(tk.presc)
	);

	// Count pin synchroniser; pin level is sensed regardless of
	// who drives it, so local drive also counts
	ebot_edge_sync u_edge (
		.i_ref_clk	(i_ref_clk),
		.i_rstn		(i_rstn),
		.i_pin		(i_ext_count_pin),
		.tk		(tk.edge_src)
	);

	assign tk.presc_clear = st_r.presc_clr;

	// Address match helper
	function automatic logic adr_is(input logic [4:0] a,
		input logic [4:0] r);
		adr_is = (a == r);
	endfunction

	// Register read mux; unmapped addresses read zero
	function automatic logic [31:0] rd_mux(input logic [4:0] a,
		input ebot_st_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (adr_is(a, 5'(`EBOT_ADDR_CTRL))) begin
			v[`EBOT_CS_MSB:`EBOT_CS_LSB] = s.clk_sel;
		end else if (adr_is(a, 5'(`EBOT_ADDR_COUNT))) begin
			v[7:0] = s.count;
		end else if (adr_is(a, 5'(`EBOT_ADDR_MASK))) begin
			v[`EBOT_OVF_BIT] = s.ovf_en;
		end else if (adr_is(a, 5'(`EBOT_ADDR_FLAGS))) begin
			v[`EBOT_OVF_BIT] = s.ovf_flag;
		end else begin
			v = 32'h0000_0000;
		end
		rd_mux = v;
	endfunction

	// Tick selection by clock-select code
	always_comb begin
		sel = ebot_cs_t'(st_r.clk_sel);
		case (sel)
			EBOT_CS_STOP:     tick = 1'b0;
			EBOT_CS_DIV1:     tick = 1'b1;
			EBOT_CS_DIV8:     tick = tk.tap_div8;
			EBOT_CS_DIV64:    tick = tk.tap_div64;
			EBOT_CS_DIV256:   tick = tk.tap_div256;
			EBOT_CS_DIV1024:  tick = tk.tap_div1024;
			EBOT_CS_EXT_FALL: tick = tk.ext_fall;
			EBOT_CS_EXT_RISE: tick = tk.ext_rise;
			default:          tick = 1'b0;
		endcase
	end

	// Bus strobes, taken only in the idle phase
	assign wr    = i_wb_cyc && i_wb_stb && i_wb_we &&
		(st_r.bus == EBOT_BUS_IDLE) && i_wb_sel[0];
	assign rd    = i_wb_cyc && i_wb_stb && !i_wb_we &&
		(st_r.bus == EBOT_BUS_IDLE);
	assign wbyte = i_wb_dat[7:0];

	// Wrap event: tick at maximum, unless a counter write wins
	assign flag_set = tick && (st_r.count == `EBOT_COUNT_MAX) &&
		!(wr && adr_is(i_wb_adr, 5'(`EBOT_ADDR_COUNT)));

	// Next-state logic for registers, counter and bus
	always_comb begin
		st_nxt           = st_r;
		st_nxt.presc_clr = 1'b0;
		// Bus handshake: ack one cycle, then drop
		case (st_r.bus)
			EBOT_BUS_IDLE: begin
				if (i_wb_cyc && i_wb_stb) begin
					st_nxt.bus = EBOT_BUS_ACK;
				end
			end
			EBOT_BUS_ACK: begin
				st_nxt.bus = EBOT_BUS_IDLE;
			end
			default: begin
				st_nxt.bus = EBOT_BUS_IDLE;
			end
		endcase
		if (rd) begin
			st_nxt.rdata = rd_mux(i_wb_adr, st_r);
		end
		// Counter: increment on tick, wrap naturally
		if (tick) begin
			st_nxt.count = st_r.count + 8'h01;
		end
		// Register writes
		if (wr && adr_is(i_wb_adr, 5'(`EBOT_ADDR_COUNT))) begin
			st_nxt.count = wbyte;
		end
		if (wr && adr_is(i_wb_adr, 5'(`EBOT_ADDR_CTRL))) begin
			st_nxt.clk_sel = wbyte[`EBOT_CS_MSB:`EBOT_CS_LSB];
		end
		if (wr && adr_is(i_wb_adr, 5'(`EBOT_ADDR_MASK))) begin
			st_nxt.ovf_en = wbyte[`EBOT_OVF_BIT];
		end
		if (wr && adr_is(i_wb_adr, `EBOT_ADDR_SFR)) begin
			st_nxt.presc_clr = wbyte[`EBOT_PSR_BIT];
		end
		// Flag clears first, a same-cycle set wins
		if (wr && adr_is(i_wb_adr, 5'(`EBOT_ADDR_FLAGS)) &&
			wbyte[`EBOT_OVF_BIT]) begin
			st_nxt.ovf_flag = 1'b0;
		end
		if (i_ovf_vector_taken) begin
			st_nxt.ovf_flag = 1'b0;
		end
		if (flag_set) begin
			st_nxt.ovf_flag = 1'b1;
		end
		st_nxt.irq = st_nxt.ovf_flag && st_nxt.ovf_en &&
			i_global_irq_enable;
	end

	// State register with synchronous reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r           <= '0;
			st_r.bus       <= EBOT_BUS_IDLE;
			st_r.clk_sel   <= 3'(`EBOT_CTRL_RST);
			st_r.count     <= `EBOT_COUNT_RST;
			st_r.ovf_en    <= 1'(`EBOT_MASK_RST);
			st_r.ovf_flag  <= 1'(`EBOT_FLAGS_RST);
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign o_wb_ack      = (st_r.bus == EBOT_BUS_ACK);
	assign o_wb_dat      = st_r.rdata;
	assign o_irq         = st_r.irq;
	assign o_count_max   = (st_r.count == `EBOT_COUNT_MAX);
	assign o_presc_clear = st_r.presc_clr;
endmodule

// File: testbench/ebot_timer_properties.sv
`timescale 1ns/1ps
// Bus and interrupt timing checks on the timer ports
module ebot_timer_properties (
	input	wire logic		i_ref_clk,
	input	wire logic		i_rstn,
	input	wire logic		i_wb_cyc,
	input	wire logic		i_wb_stb,
	input	wire logic [31:0]	o_wb_dat,
	input	wire logic		o_wb_ack,
	input	wire logic		i_global_irq_enable,
	input	wire logic		i_ovf_vector_taken,
	input	wire logic		o_irq,
	input	wire logic		o_count_max,
	input	wire logic		o_presc_clear
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	// Request taken while the slave is idle
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// Acknowledge that lasts one cycle
	sequence s_ack;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	property p_ack;
		s_req |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("late ack");
	property p_noack;
		!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack;
	endproperty
	a_noack: assert property (p_noack) else $error("stray ack");
	property p_upper;
		o_wb_ack |-> o_wb_dat[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper data");
	property p_irqge;
		o_irq |-> $past(i_global_irq_enable);
	endproperty
	a_irqge: assert property (p_irqge) else $error("irq no enable");
	property p_irqoff;
		!i_global_irq_enable |=> !o_irq;
	endproperty
	a_irqoff: assert property (p_irqoff) else $error("irq held");
	// Vector entry without a coincident wrap drops the request
	property p_vec;
		i_ovf_vector_taken && !o_count_max |=> !o_irq;
	endproperty
	a_vec: assert property (p_vec) else $error("vector kept flag");
	// Counting never clears the flag, so the request holds
	property p_hold;
		o_irq && i_global_irq_enable && !i_ovf_vector_taken
			&& !(i_wb_cyc && i_wb_stb && !o_wb_ack)
			&& !$past(i_ovf_vector_taken) |=> o_irq;
	endproperty
	a_hold: assert property (p_hold) else $error("irq lost");
	// Prescaler restart only follows a bus write
	property p_psc;
		o_presc_clear |-> o_wb_ack || $past(o_wb_ack)
			|| $past(o_wb_ack, 2);
	endproperty
	a_psc: assert property (p_psc) else $error("stray restart");
endmodule

bind ebot_timer ebot_timer_properties ebot_timer_properties_inst (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_global_irq_enable(i_global_irq_enable),
	.i_ovf_vector_taken(i_ovf_vector_taken), .o_irq(o_irq),
	.o_count_max(o_count_max), .o_presc_clear(o_presc_clear)
);

// File: testbench/tb_eight_bit_overflow_timer.sv
`timescale 1ns/1ps
// Self-checking bench for the overflow timer
module tb_eight_bit_overflow_timer;
	logic		i_ref_clk = 1'b0;
	logic		i_rstn = 1'b0;
	logic		i_wb_cyc = 1'b0;
	logic		i_wb_stb = 1'b0;
	logic		i_wb_we = 1'b0;
	logic [4:0]	i_wb_adr = 5'h00;
	logic [3:0]	i_wb_sel = 4'hF;
	logic [31:0]	i_wb_dat = 32'h0;
	logic		i_ext_count_pin = 1'b0;
	logic		i_global_irq_enable = 1'b0;
	logic		i_ovf_vector_taken = 1'b0;
	logic [31:0]	o_wb_dat;
	logic		o_wb_ack, o_irq, o_count_max, o_presc_clear;
	logic [31:0]	rd;
	logic		pc;
	int		fails = 0;
	int		tests_run = 0;
	int		n;
	// Rows: write flag, address, write byte, expected read byte
	logic [21:0]	rows [15] = '{22'h000000, 22'h040000, 22'h080000,
		22'h0C0000, 22'h100000, 22'h20FF00, 22'h000007, 22'h200000,
		22'h245A00, 22'h04005A, 22'h280100, 22'h080001, 22'h140000,
		22'h300100, 22'h100000};
	// Tick period of each select code from 1 up
	int		divs [5] = '{1, 8, 64, 256, 1024};

	// Clock of 8 ns
	always #4 i_ref_clk = ~i_ref_clk;

	ebot_timer ebot_timer_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.i_ext_count_pin(i_ext_count_pin),
		.i_global_irq_enable(i_global_irq_enable),
		.i_ovf_vector_taken(i_ovf_vector_taken), .o_irq(o_irq),
		.o_count_max(o_count_max), .o_presc_clear(o_presc_clear));

	// Closing report
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Compare a seen value with its expectation
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// Bounded wait ran out
	task automatic expire();
		fails++;
		$display("mismatch at %0t: wait ran out", $time);
		print_verdict();
	endtask
	// One classic Wishbone cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [7:0] d);
		int k;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= {24'h0, d};
		k = 0;
		@(posedge i_ref_clk);
		while (o_wb_ack !== 1'b1) begin
			if (++k > 20)
				expire();
			@(posedge i_ref_clk);
		end
		rd = o_wb_dat;
		pc = o_presc_clear;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	// Read a register and compare the whole word
	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	// Let cycles pass
	task automatic idle(input int c);
		repeat (c) @(posedge i_ref_clk);
	endtask

	// Main sequence
	initial begin
		idle(2);
		i_rstn <= 1'b1;
		foreach (rows[i]) begin
			wb(rows[i][21], rows[i][20:16], rows[i][15:8]);
			if (!rows[i][21])
				chk(rd, {24'h0, rows[i][7:0]});
		end
		$display("register rows done");
		// Each rate: time spent at the maximum equals the tick period
		foreach (divs[i]) begin
			wb(1'b1, 5'h0C, 8'h01);
			wb(1'b1, 5'h00, 8'(i + 1));
			wb(1'b1, 5'h04, 8'hFD);
			n = 0;
			while (o_count_max !== 1'b1) begin
				if (++n > 3000)
					expire();
				@(posedge i_ref_clk);
			end
			n = 0;
			while (o_count_max === 1'b1 && n < 3000) begin
				n++;
				@(posedge i_ref_clk);
			end
			chk(32'(n), 32'(divs[i]));
			wb(1'b1, 5'h00, 8'h00);
			rc(5'h0C, 8'h01);
		end
		$display("rate test done");
		// Pin edges, falling then rising
		for (int c = 6; c < 8; c++) begin
			wb(1'b1, 5'h04, 8'h00);
			wb(1'b1, 5'h00, 8'(c));
			repeat (3) begin
				i_ext_count_pin <= 1'b1;
				idle(4);
				i_ext_count_pin <= 1'b0;
				idle(4);
			end
			wb(1'b1, 5'h00, 8'h00);
			rc(5'h04, 8'h03);
		end
		$display("pin test done");
		// Interrupt gating and clearing
		wb(1'b1, 5'h0C, 8'h00);
		rc(5'h0C, 8'h01);
		chk(32'(o_irq), 32'h0);
		i_global_irq_enable <= 1'b1;
		idle(2);
		chk(32'(o_irq), 32'h1);
		wb(1'b1, 5'h08, 8'h00);
		chk(32'(o_irq), 32'h0);
		wb(1'b1, 5'h08, 8'h01);
		chk(32'(o_irq), 32'h1);
		i_ovf_vector_taken <= 1'b1;
		idle(1);
		i_ovf_vector_taken <= 1'b0;
		idle(2);
		chk(32'(o_irq), 32'h0);
		rc(5'h0C, 8'h00);
		$display("interrupt test done");
		// Byte lane zero disabled: the counter write is ignored
		i_wb_sel <= 4'hE;
		wb(1'b1, 5'h04, 8'h77);
		i_wb_sel <= 4'hF;
		rc(5'h04, 8'h03);
		// Prescaler restart pulses once, a zero write does nothing
		wb(1'b1, 5'h10, 8'h01);
		chk(32'(pc), 32'h1);
		chk(32'(o_presc_clear), 32'h0);
		wb(1'b1, 5'h10, 8'h00);
		chk(32'(pc), 32'h0);
		$display("lane and restart test done");
		// Reset while counting
		wb(1'b1, 5'h00, 8'h01);
		i_rstn <= 1'b0;
		idle(2);
		i_rstn <= 1'b1;
		rc(5'h00, 8'h00);
		rc(5'h04, 8'h00);
		rc(5'h08, 8'h00);
		$display("reset test done");
		print_verdict();
	end
endmodule
